// ===== rtl/pbc_pkg.sv
package pbc_pkg;

    // ========================================================
    // Register byte offsets
    localparam logic [7:0] PBC_OFS_CTRL    = 8'h00;
    localparam logic [7:0] PBC_OFS_CFG     = 8'h04;
    localparam logic [7:0] PBC_OFS_OUTCFG  = 8'h08;
    localparam logic [7:0] PBC_OFS_POS     = 8'h0c;
    localparam logic [7:0] PBC_OFS_MOD     = 8'h10;
    localparam logic [7:0] PBC_OFS_STATUS  = 8'h14;
    localparam logic [7:0] PBC_OFS_INT_CLR = 8'h18;
    localparam logic [7:0] PBC_OFS_INT_EN  = 8'h1c;
    localparam logic [7:0] PBC_OFS_TGT_LO  = 8'h20;
    localparam logic [7:0] PBC_OFS_TGT_HI  = 8'h24;

    // ========================================================
    // Field positions
    localparam int PBC_CFG_OP      = 0;
    localparam int PBC_CFG_MODE_LO = 1;
    localparam int PBC_CFG_ACT_LO  = 3;
    localparam int PBC_CFG_SRC_LO  = 8;
    localparam int PBC_OUT_POL     = 0;
    localparam int PBC_OUT_DRV     = 1;
    localparam int PBC_ST_EVENT    = 0;
    localparam int PBC_ST_MODERR   = 1;
    localparam int PBC_ST_ENABLED  = 2;
    localparam int PBC_ST_OUTSTATE = 3;
    localparam int PBC_ST_W        = 2;

    // ========================================================
    // Source identifiers
    localparam logic [7:0] PBC_SRC_AXIS_FIRST = 8'h01;
    localparam logic [7:0] PBC_SRC_ENC_FIRST  = 8'h21;

    // ========================================================
    // Reset values
    localparam logic [15:0] PBC_CFG_RST    = 16'h0100;
    localparam logic [1:0]  PBC_OUTCFG_RST = 2'h3;

    // ========================================================
    // Encodings
    typedef enum logic [1:0] {
        PBC_MODE_ABS = 2'h0,
        PBC_MODE_REL = 2'h1,
        PBC_MODE_MOD = 2'h2
    } pbc_mode_t;

    typedef enum logic [1:0] {
        PBC_ACT_NONE   = 2'h0,
        PBC_ACT_LOW    = 2'h1,
        PBC_ACT_HIGH   = 2'h2,
        PBC_ACT_TOGGLE = 2'h3
    } pbc_act_t;

    typedef struct packed {
        logic [7:0] src;
        pbc_act_t   action;
        pbc_mode_t  mode;
        logic       buffered;
    } pbc_cfg_t;

    typedef struct packed {
        logic active_high;
        logic push_pull;
    } pbc_outcfg_t;

endpackage

// ===== rtl/pbc_top.sv
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - Single or buffered operation chosen by configuration before enable.
// - Source is axis encoder 1..8 or independent encoder 0x21..0x28.
// - Event applies action: unchanged, low, high or toggle output.
// - At enable, output already at action level is first forced opposite.
// - Modulo enable with value magnitude not below modulus is refused, modal error.
// - Absolute mode compares value directly over full signed 32-bit range.
// - Relative target is value plus position captured at enable and again at each buffered re-arm.
// - Modulo value is an offset inside every modulus period.
// - Reaching an enabled breakpoint raises an event and readable status.
// - Output polarity selects whether asserted state is low or high pin.
// - Output driver selectable open-collector or push-pull.
// - No comparison on an axis whose feedback is analog.
// - Single operation disables itself on event; buffered stays enabled.
// - Modulus is shadowed, copied to compare logic only at enable.
// - Modulo enable arms one target ahead and one behind position when the value is not negative.
module pbc_top
    import pbc_pkg::*;
#(
    parameter int N_AXES = 8,
    parameter int N_ENC  = 8
) (
    input  wire logic                     CLK,
    input  wire logic                     RST_N,
    input  wire logic                     PSEL,
    input  wire logic                     PENABLE,
    input  wire logic                     PWRITE,
    input  wire logic [7:0]               PADDR,
    input  wire logic [31:0]              PWDATA,
    output logic      [31:0]              PRDATA,
    output logic                          PREADY,
    output logic                          PSLVERR,
    input  wire logic [N_AXES-1:0][31:0]  AXIS_POS,
    input  wire logic [N_AXES-1:0]        AXIS_ANALOG,
    input  wire logic [N_ENC-1:0][31:0]   ENC_POS,
    output logic                          BP_OUT,
    output logic                          BP_OE,
    output logic                          BP_EVENT,
    output logic                          IRQ
);

    // ========================================================
    // Elaboration checks
    if (N_AXES < 1 || N_AXES > 8 || N_ENC < 1 || N_ENC > 8) begin : g_chk
        $error("pbc_top: N_AXES and N_ENC must be 1..8");
    end

    // ========================================================
    // Source decode
    typedef struct packed {
        logic       valid;
        logic       is_axis;
        logic [2:0] idx;
    } pbc_srcdec_t;

    function automatic pbc_srcdec_t decode_src(input logic [7:0] s);
        pbc_srcdec_t d;
        logic [7:0]  ao;
        logic [7:0]  eo;
        ao = s - PBC_SRC_AXIS_FIRST;
        eo = s - PBC_SRC_ENC_FIRST;
        d = '0;
        if (s >= PBC_SRC_AXIS_FIRST && ao < 8'(N_AXES)) begin
            d.valid   = 1'b1;
            d.is_axis = 1'b1;
            d.idx     = ao[2:0];
        end else if (s >= PBC_SRC_ENC_FIRST && eo < 8'(N_ENC)) begin
            d.valid = 1'b1;
            d.idx   = eo[2:0];
        end
        return d;
    endfunction

    // Register word layout to struct, shared by reset and writes
    function automatic pbc_cfg_t cfg_unpack(input logic [15:0] w);
        return '{src:      w[PBC_CFG_SRC_LO +: 8],
                 action:   pbc_act_t'(w[PBC_CFG_ACT_LO +: 2]),
                 mode:     pbc_mode_t'(w[PBC_CFG_MODE_LO +: 2]),
                 buffered: w[PBC_CFG_OP]};
    endfunction

    function automatic logic crossed(input logic signed [31:0] p, input logic signed [31:0] c,
                                     input logic signed [31:0] t);
        return (c == t) || (p < t && c > t) || (p > t && c < t);
    endfunction

    // ========================================================
    // State
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_ARM    = 3'b010,
        ST_ACTIVE = 3'b100
    } pbc_state_t;

    pbc_state_t         state_r, state_nxt;
    pbc_cfg_t           cfg_r;
    pbc_cfg_t           run_cfg_r;
    pbc_outcfg_t        outcfg_r;
    logic signed [31:0] pos_val_r;
    logic        [31:0] mod_shadow_r;
    logic        [31:0] mod_act_r;
    logic signed [31:0] tgt_lo_r;
    logic signed [31:0] tgt_hi_r;
    logic signed [31:0] prev_r;
    logic               out_state_r;
    logic [PBC_ST_W-1:0] status_r;
    logic [PBC_ST_W-1:0] int_en_r;
    logic [31:0]        prdata_r;

    // ========================================================
    // APB decode
    wire        setup_ph  = PSEL && !PENABLE;
    wire        access_ph = PSEL && PENABLE;
    wire        wr        = access_ph && PWRITE;
    wire        mapped    = (PADDR[1:0] == 2'b00) && (PADDR <= PBC_OFS_TGT_HI);
    wire        wr_ctrl   = wr && PADDR == PBC_OFS_CTRL;
    wire        wr_cfg    = wr && PADDR == PBC_OFS_CFG;
    wire        wr_outcfg = wr && PADDR == PBC_OFS_OUTCFG;
    wire        wr_pos    = wr && PADDR == PBC_OFS_POS;
    wire        wr_mod    = wr && PADDR == PBC_OFS_MOD;
    wire        wr_clr    = wr && PADDR == PBC_OFS_INT_CLR;
    wire        wr_inten  = wr && PADDR == PBC_OFS_INT_EN;
    wire        en_req    = wr_ctrl && PWDATA[0];
    wire        dis_req   = wr_ctrl && !PWDATA[0];

    assign PREADY  = 1'b1;
    assign PSLVERR = access_ph && !mapped;
    assign PRDATA  = prdata_r;

    // ========================================================
    // Position selection
    pbc_srcdec_t        sd_cfg;
    pbc_srcdec_t        sd_run;
    logic signed [31:0] cur_pos;
    assign sd_cfg  = decode_src(cfg_r.src);
    assign sd_run  = decode_src(run_cfg_r.src);
    assign cur_pos = sd_run.is_axis ? AXIS_POS[sd_run.idx] : ENC_POS[sd_run.idx];

    // ========================================================
    // Enable checks
    wire [31:0] val_mag   = pos_val_r[31] ? 32'(-pos_val_r) : pos_val_r;
    wire [31:0] mod_new   = {1'b0, mod_shadow_r[30:0]};
    wire        mod_bad   = cfg_r.mode == PBC_MODE_MOD && mod_new != 32'h0 &&
                            val_mag >= mod_new;
    wire        analog_fb = sd_cfg.is_axis && AXIS_ANALOG[sd_cfg.idx];
    wire        en_ok     = en_req && !mod_bad && sd_cfg.valid && !analog_fb;
    wire        en_err    = en_req && !en_ok;

    // ========================================================
    // Target arithmetic
    wire signed [31:0] m_s     = signed'(mod_act_r);
    wire               mod_on  = run_cfg_r.mode == PBC_MODE_MOD && mod_act_r != 32'h0;
    wire signed [31:0] rem_raw = mod_on ? cur_pos % m_s : 32'sh0;
    wire signed [31:0] rem     = rem_raw < 0 ? rem_raw + m_s : rem_raw;
    wire signed [31:0] mod_tgt = cur_pos - rem + pos_val_r;
    wire               tgt_up  = mod_tgt > cur_pos;
    logic signed [31:0] arm_lo;
    logic signed [31:0] arm_hi;
    always_comb begin
        arm_lo = pos_val_r;
        arm_hi = pos_val_r;
        if (run_cfg_r.mode == PBC_MODE_REL) begin
            arm_lo = cur_pos + pos_val_r;
            arm_hi = cur_pos + pos_val_r;
        end else if (mod_on) begin
            arm_lo = tgt_up ? mod_tgt - m_s : mod_tgt;
            arm_hi = tgt_up ? mod_tgt : mod_tgt + m_s;
        end
    end

    wire hit = state_r == ST_ACTIVE &&
               (crossed(prev_r, cur_pos, tgt_lo_r) || crossed(prev_r, cur_pos, tgt_hi_r));

    // ========================================================
    // Control sequence
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:   if (en_ok) state_nxt = ST_ARM;
            ST_ARM:    state_nxt = dis_req ? ST_IDLE : ST_ACTIVE;
            ST_ACTIVE: begin
                if (dis_req) begin
                    state_nxt = ST_IDLE;
                end else if (en_ok) begin
                    state_nxt = ST_ARM;
                end else if (hit) begin
                    state_nxt = run_cfg_r.buffered ? ST_ARM : ST_IDLE;
                end
            end
            default:   state_nxt = ST_IDLE;
        endcase
    end

    // Output action and pre-drive on arm
    logic out_nxt;
    wire  arm_entry = state_r != ST_ARM && state_nxt == ST_ARM && en_ok;
    always_comb begin
        out_nxt = out_state_r;
        if (hit && state_nxt != ST_ARM || hit && run_cfg_r.buffered && !en_ok) begin
            unique case (run_cfg_r.action)
                PBC_ACT_NONE:   out_nxt = out_state_r;
                PBC_ACT_LOW:    out_nxt = 1'b0;
                PBC_ACT_HIGH:   out_nxt = 1'b1;
                PBC_ACT_TOGGLE: out_nxt = !out_state_r;
            endcase
        end else if (arm_entry) begin
            if (cfg_r.action == PBC_ACT_LOW && !out_state_r) out_nxt = 1'b1;
            if (cfg_r.action == PBC_ACT_HIGH && out_state_r) out_nxt = 1'b0;
        end
    end

    // ========================================================
    // Status and interrupt
    wire [PBC_ST_W-1:0] ev_set   = {en_err, hit};
    wire [PBC_ST_W-1:0] ev_clr   = wr_clr ? PWDATA[PBC_ST_W-1:0] : '0;
    wire [PBC_ST_W-1:0] new_en   = {1'b0, arm_entry};
    wire [PBC_ST_W-1:0] status_nxt = ev_set | (status_r & ~ev_clr & ~new_en);
    assign IRQ      = |(status_r & int_en_r);
    assign BP_EVENT = hit;

    // ========================================================
    // Pin driver
    wire pin_level = outcfg_r.active_high ? out_state_r : !out_state_r;
    assign BP_OUT = outcfg_r.push_pull ? pin_level : 1'b0;
    assign BP_OE  = outcfg_r.push_pull ? 1'b1 : !pin_level;

    // ========================================================
    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        unique case (PADDR)
            PBC_OFS_CTRL:   rd_mux = {31'h0, state_r != ST_IDLE};
            PBC_OFS_CFG:    rd_mux = {16'h0, cfg_r.src, 3'h0, cfg_r.action, cfg_r.mode,
                                      cfg_r.buffered};
            PBC_OFS_OUTCFG: rd_mux = {30'h0, outcfg_r.push_pull, outcfg_r.active_high};
            PBC_OFS_POS:    rd_mux = pos_val_r;
            PBC_OFS_MOD:    rd_mux = mod_shadow_r;
            PBC_OFS_STATUS: rd_mux = {28'h0, out_state_r, state_r != ST_IDLE, status_r};
            PBC_OFS_INT_EN: rd_mux = {30'h0, int_en_r};
            PBC_OFS_TGT_LO: rd_mux = tgt_lo_r;
            PBC_OFS_TGT_HI: rd_mux = tgt_hi_r;
            default:        rd_mux = 32'h0;
        endcase
    end

    // ========================================================
    // Registers
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cfg_r        <= cfg_unpack(PBC_CFG_RST);
            outcfg_r     <= pbc_outcfg_t'(PBC_OUTCFG_RST);
            pos_val_r    <= 32'sh0;
            mod_shadow_r <= 32'h0;
            int_en_r     <= '0;
            prdata_r     <= 32'h0;
        end else begin
            if (wr_cfg) cfg_r <= cfg_unpack(PWDATA[15:0]);
            if (wr_outcfg) begin
                outcfg_r <= '{active_high: PWDATA[PBC_OUT_POL], push_pull: PWDATA[PBC_OUT_DRV]};
            end
            if (wr_pos) pos_val_r <= PWDATA;
            if (wr_mod) mod_shadow_r <= PWDATA;
            if (wr_inten) int_en_r <= PWDATA[PBC_ST_W-1:0];
            if (setup_ph) prdata_r <= rd_mux;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_r     <= ST_IDLE;
            run_cfg_r   <= cfg_unpack(PBC_CFG_RST);
            mod_act_r   <= 32'h0;
            tgt_lo_r    <= 32'sh0;
            tgt_hi_r    <= 32'sh0;
            prev_r      <= 32'sh0;
            out_state_r <= 1'b0;
            status_r    <= '0;
        end else begin
            state_r     <= state_nxt;
            out_state_r <= out_nxt;
            status_r    <= status_nxt;
            prev_r      <= cur_pos;
            if (en_ok) begin
                run_cfg_r <= cfg_r;
                mod_act_r <= mod_new;
            end
            if (state_r == ST_ARM) begin
                tgt_lo_r <= arm_lo;
                tgt_hi_r <= arm_hi;
            end
        end
    end

    // ========================================================
    // Assertions
    sequence s_enable_ok;
        en_ok && state_r != ST_ARM;
    endsequence

    sequence s_armed;
        state_r == ST_ARM ##1 state_r == ST_ACTIVE;
    endsequence

    a_arm_then_active: assert property (@(posedge CLK) disable iff (!RST_N)
        s_enable_ok |=> s_armed or (state_r == ST_ARM ##1 state_r == ST_IDLE))
        else $error("enable did not arm then activate");

    a_modal_error_set: assert property (@(posedge CLK) disable iff (!RST_N)
        en_req && mod_bad && !hit && state_r != ST_ARM
        |=> status_r[PBC_ST_MODERR] && state_r == $past(state_r))
        else $error("modulo range violation not refused");

    a_analog_refused: assert property (@(posedge CLK) disable iff (!RST_N)
        en_req && analog_fb && state_r == ST_IDLE |=> state_r == ST_IDLE)
        else $error("analog feedback axis was armed");

    a_single_clears: assert property (@(posedge CLK) disable iff (!RST_N)
        hit && !run_cfg_r.buffered && !PSEL |=> state_r == ST_IDLE)
        else $error("single breakpoint stayed enabled");

    a_buffered_rearm: assert property (@(posedge CLK) disable iff (!RST_N)
        hit && run_cfg_r.buffered && !PSEL |=> state_r == ST_ARM ##1 state_r == ST_ACTIVE)
        else $error("buffered breakpoint did not re-arm");

    a_event_sticky: assert property (@(posedge CLK) disable iff (!RST_N)
        hit |=> status_r[PBC_ST_EVENT] until_with (ev_clr[PBC_ST_EVENT] || arm_entry))
        else $error("event bit lost early");

    a_action_high: assert property (@(posedge CLK) disable iff (!RST_N)
        hit && run_cfg_r.action == PBC_ACT_HIGH && !en_ok |=> out_state_r)
        else $error("high action not applied");

    a_toggle: assert property (@(posedge CLK) disable iff (!RST_N)
        hit && run_cfg_r.action == PBC_ACT_TOGGLE && !en_ok |=> out_state_r != $past(out_state_r))
        else $error("toggle action not applied");

    a_predrive: assert property (@(posedge CLK) disable iff (!RST_N)
        arm_entry && cfg_r.action == PBC_ACT_LOW |=> out_state_r)
        else $error("output not forced opposite at enable");

    a_polarity_pin: assert property (@(posedge CLK) disable iff (!RST_N)
        outcfg_r.push_pull |-> BP_OUT == (out_state_r ~^ outcfg_r.active_high))
        else $error("pin level disagrees with polarity");

    a_open_coll: assert property (@(posedge CLK) disable iff (!RST_N)
        !outcfg_r.push_pull |-> !BP_OUT && BP_OE == !pin_level)
        else $error("open collector drives high");

    a_rel_target: assert property (@(posedge CLK) disable iff (!RST_N)
        state_r == ST_ARM && run_cfg_r.mode == PBC_MODE_REL
        |=> tgt_lo_r == $past(cur_pos) + $past(pos_val_r))
        else $error("relative target wrong");

    a_mod_bracket: assert property (@(posedge CLK) disable iff (!RST_N)
        state_r == ST_ARM && mod_on |=> tgt_hi_r - tgt_lo_r == m_s && tgt_lo_r <= $past(cur_pos))
        else $error("modulo targets do not bracket position");

endmodule

// ===== bench/pbc_enc_model.sv
`timescale 1ns/1ps
module pbc_enc_model (
    input  wire logic                CLK,
    input  wire logic                RST_N,
    input  wire logic [3:0]          sel,
    input  wire logic signed [31:0]  goal,
    input  wire logic                bp_out,
    input  wire logic                bp_oe,
    output logic      [7:0][31:0]    axis_pos,
    output logic      [7:0][31:0]    enc_pos,
    output logic signed [31:0]       cur,
    output logic                     pin
);
    logic signed [31:0] pos_r [16];

    // ========================================================
    // Output load
    // Released open collector: the load pulls the pin up
    assign pin = bp_oe ? bp_out : 1'b1;
    assign cur = pos_r[sel];

    // ========================================================
    // Encoder feedback
    // One count per clock, so a target is never jumped over
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pos_r <= '{default: '0};
        end else if (pos_r[sel] < goal) begin
            pos_r[sel] <= pos_r[sel] + 32'sh1;
        end else if (pos_r[sel] > goal) begin
            pos_r[sel] <= pos_r[sel] - 32'sh1;
        end
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            axis_pos[i] = pos_r[i];
            enc_pos[i]  = pos_r[i+8];
        end
    end
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import pbc_pkg::*;
    logic                    clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]              paddr = '0, analog = '0;
    logic [31:0]             pwdata = '0, prdata, q, lo;
    logic                    pready, pslverr, e, bp_out, bp_oe, bp_event, irq, pin;
    logic [3:0]              sel = '0;
    logic signed [31:0]      goal = '0, cur, at;
    logic [7:0][31:0]        axis_pos, enc_pos;
    int                      n_errors = 0, checked = 0, nh;

    always #2.5 clk = ~clk;

    pbc_top i_pbc_top (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .AXIS_POS(axis_pos), .AXIS_ANALOG(analog),
        .ENC_POS(enc_pos), .BP_OUT(bp_out), .BP_OE(bp_oe), .BP_EVENT(bp_event), .IRQ(irq));
    pbc_enc_model i_pbc_enc_model (.CLK(clk), .RST_N(rst_n), .sel(sel), .goal(goal),
        .bp_out(bp_out), .bp_oe(bp_oe), .axis_pos(axis_pos), .enc_pos(enc_pos),
        .cur(cur), .pin(pin));

    // ========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checked++;
        if (g !== x) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] a);
        xfer(a, 1'b0, 32'h0);
    endtask

    // Moves the selected position to g, counting breakpoint events on the way
    task automatic go(input logic signed [31:0] g);
        nh = 0;
        @(posedge clk);
        goal <= g;
        repeat (3000) begin
            @(negedge clk);
            if (bp_event === 1'b1) begin
                nh++;
                at = cur;
            end
            if (cur === g) break;
        end
        chk("go_target", g, cur);
    endtask

    task automatic give_verdict;
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ========================================================
    // Scenarios
    task automatic t_rst;
        rd(PBC_OFS_CFG);   chk("cfg_rst", {16'h0, PBC_CFG_RST}, q);
        rd(PBC_OFS_OUTCFG); chk("outcfg_rst", {30'h0, PBC_OUTCFG_RST}, q);
        chk("oe_pin_rst", 32'h2, {30'h0, bp_oe, pin});
        rd(8'h28);
        chk("unmapped_err", 32'h1, {31'h0, e});
        chk("unmapped_data", 32'h0, q);
    endtask

    // Output set up before any enable, idle logical state 0
    task automatic t_out;
        logic [1:0] x [4] = '{2'b01, 2'b10, 2'b11, 2'b10};
        for (int i = 0; i < 4; i++) begin
            wr(PBC_OFS_OUTCFG, i);
            @(negedge clk);
            chk("outcfg_oe_pin", {30'h0, x[i]}, {30'h0, bp_oe, pin});
        end
        wr(PBC_OFS_INT_EN, 32'h3);
    endtask

    task automatic t_abs;
        wr(PBC_OFS_CFG, 32'h0110);
        wr(PBC_OFS_POS, 32'hffff_fffb);
        wr(PBC_OFS_CTRL, 32'h1);
        go(32'hffff_ffec);
        chk("abs_hits", 32'h1, nh);
        chk("abs_at", 32'hffff_fffb, at);
        chk("abs_pin", 32'h1, {31'h0, pin});
        chk("abs_irq", 32'h1, {31'h0, irq});
        rd(PBC_OFS_STATUS); chk("abs_status", 32'h9, q[3:0]);
        go(32'h0);
        chk("single_rehit", 32'h0, nh);
    endtask

    task automatic t_pre;
        wr(PBC_OFS_POS, 32'hffff_ff9c);
        wr(PBC_OFS_CTRL, 32'h1);
        @(negedge clk);
        chk("pre_pin", 32'h0, {31'h0, pin});
        rd(PBC_OFS_STATUS); chk("pre_status", 32'h4, q[2:0]);
        wr(PBC_OFS_CTRL, 32'h0);
        rd(PBC_OFS_STATUS); chk("disabled", 32'h0, q[2]);
    endtask

    task automatic t_rel;
        go(32'h28);
        wr(PBC_OFS_CFG, 32'h010a);
        wr(PBC_OFS_POS, 32'h7);
        wr(PBC_OFS_CTRL, 32'h1);
        @(negedge clk);
        chk("rel_pre_pin", 32'h1, {31'h0, pin});
        go(32'h3c);
        chk("rel_at", 32'h2f, at);
        chk("rel_pin", 32'h0, {31'h0, pin});
    endtask

    task automatic t_mod;
        wr(PBC_OFS_CFG, 32'h011c);
        wr(PBC_OFS_MOD, 32'h3e8);
        wr(PBC_OFS_POS, 32'hffff_fc18);
        wr(PBC_OFS_CTRL, 32'h1);
        rd(PBC_OFS_STATUS); chk("mod_refused", 32'h3, q[2:0]);
        chk("moderr_irq", 32'h1, {31'h0, irq});
        wr(PBC_OFS_INT_CLR, 32'h2);
        go(32'hc8);
        wr(PBC_OFS_POS, 32'h12c);
        wr(PBC_OFS_CTRL, 32'h1);
        wr(PBC_OFS_MOD, 32'h5);
        rd(PBC_OFS_TGT_LO); lo = q;
        rd(PBC_OFS_TGT_HI);
        chk("mod_tgts", 32'h1, (lo === 32'h12c && q === 32'hffff_fd44) ||
            (q === 32'h12c && lo === 32'hffff_fd44));
        go(32'h190);
        chk("mod_at", 32'h12c, at);
        chk("toggle_pin", 32'h1, {31'h0, pin});
    endtask

    task automatic t_buf;
        @(posedge clk);
        sel <= 4'h8;
        goal <= 32'h0;
        wr(PBC_OFS_CFG, 32'h2119);
        wr(PBC_OFS_POS, 32'ha);
        wr(PBC_OFS_INT_CLR, 32'h3);
        wr(PBC_OFS_CTRL, 32'h1);
        go(32'h14);
        chk("enc_at", 32'ha, at);
        chk("buf_pin1", 32'h0, {31'h0, pin});
        rd(PBC_OFS_STATUS); chk("buf_enabled", 32'h1, q[2]);
        wr(PBC_OFS_INT_CLR, 32'h1);
        @(negedge clk);
        chk("irq_clr", 32'h0, {31'h0, irq});
        go(32'h0);
        chk("buf_hits", 32'h1, nh);
        chk("buf_pin2", 32'h1, {31'h0, pin});
        wr(PBC_OFS_CTRL, 32'h0);
    endtask

    task automatic t_ref;
        logic [7:0] s [3] = '{8'h02, 8'h09, 8'h29};
        @(posedge clk);
        analog <= 8'h02;
        for (int i = 0; i < 3; i++) begin
            wr(PBC_OFS_CFG, {16'h0, s[i], 8'h00});
            wr(PBC_OFS_INT_CLR, 32'h3);
            wr(PBC_OFS_CTRL, 32'h1);
            rd(PBC_OFS_STATUS); chk("src_refused", 32'h1, q[2:1]);
        end
        wr(PBC_OFS_CFG, 32'h2800);
        wr(PBC_OFS_POS, 32'h7fff_0000);
        wr(PBC_OFS_INT_CLR, 32'h3);
        wr(PBC_OFS_CTRL, 32'h1);
        rd(PBC_OFS_STATUS); chk("src_last_enc", 32'h2, q[2:1]);
    endtask

    // ========================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_rst();
        t_out();
        t_abs();
        t_pre();
        t_rel();
        t_mod();
        t_buf();
        t_ref();
        give_verdict();
    end

    initial begin
        #300000;
        n_errors++;
        give_verdict();
    end
endmodule
